//--- rtl/dis_host.sv
// two-wire master that sends dac channel updates ordered over axi4-lite
// assumes the link pull-ups and a 200 MHz aclk
`timescale 1ns/1ps
module dis_host (
  input logic aclk,
  input logic aresetn,
  input logic [3:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input logic [3:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready,
  dis_link_if.master link
);
  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} dis_host_e;

  typedef struct packed {
    logic aw_ok;
    logic [3:0] aw_a;
    logic w_ok;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
    logic [dis_pkg::CMD_W-1:0] cmd;
    logic [1:0] cfg;
    logic busy;
    logic nack;
    logic sess;
    dis_host_e st;
    logic [dis_pkg::QTR_W-1:0] qtr;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [1:0] byt;
    logic [7:0] sh;
    logic scl_low;
    logic sda_low;
    logic sda_m;
    logic sda_s;
  } dis_host_s;

  dis_host_s q_r;
  dis_host_s q_nxt;
  logic [31:0] wv;
  logic tick;

  function automatic logic [31:0] reg_rd(input logic [3:0] a);
    case (a)
      dis_pkg::REG_CMD: reg_rd = 32'(q_r.cmd);
      dis_pkg::REG_STAT: reg_rd = {29'h0, q_r.sess, q_r.nack, q_r.busy};
      dis_pkg::REG_CFG: reg_rd = {30'h0, q_r.cfg};
      default: reg_rd = 32'h0;
    endcase
  endfunction

  function automatic logic [7:0] byte_val(input logic [1:0] i);
    case (i)
      2'h0: byte_val = {dis_pkg::ADDR_FIXED, q_r.cfg, 1'h0};
      2'h1: byte_val = {2'h0, q_r.cmd[dis_pkg::CH_W-1:0]};
      2'h2: byte_val = {q_r.cmd[dis_pkg::CMD_RS_LSB +: 2], q_r.cmd[21:16]};
      default: byte_val = q_r.cmd[15:8];
    endcase
  endfunction

  assign awready = !q_r.aw_ok && !q_r.bv;
  assign wready = !q_r.w_ok && !q_r.bv;
  assign arready = !q_r.rv;
  assign bvalid = q_r.bv;
  assign bresp = q_r.br;
  assign rvalid = q_r.rv;
  assign rdata = q_r.rd;
  assign rresp = q_r.rr;
  assign tick = (q_r.qtr == dis_pkg::QTR_LAST);
  assign link.m_scl_o = 1'h0;
  assign link.m_scl_oe = q_r.scl_low;
  assign link.m_sda_o = 1'h0;
  assign link.m_sda_oe = q_r.sda_low;

  // ****************************************
  // register slave and bit engine
  // ****************************************
  always_comb begin
    q_nxt = q_r;
    wv = reg_rd(q_r.aw_a);
    for (int i = 0; i < 4; i++) begin
      if (q_r.w_s[i]) begin
        wv[8*i +: 8] = q_r.w_d[8*i +: 8];
      end
    end
    if (awvalid && awready) begin
      q_nxt.aw_ok = 1'h1;
      q_nxt.aw_a = awaddr;
    end
    if (wvalid && wready) begin
      q_nxt.w_ok = 1'h1;
      q_nxt.w_d = wdata;
      q_nxt.w_s = wstrb;
    end
    if (q_r.aw_ok && q_r.w_ok) begin
      q_nxt.aw_ok = 1'h0;
      q_nxt.w_ok = 1'h0;
      q_nxt.bv = 1'h1;
      q_nxt.br = dis_pkg::RESP_OKAY;
      case (q_r.aw_a)
        dis_pkg::REG_CMD: begin
          // a command while busy is dropped
          if (!q_r.busy) begin
            q_nxt.cmd = wv[dis_pkg::CMD_W-1:0];
            q_nxt.busy = 1'h1;
            q_nxt.nack = 1'h0;
          end
        end
        dis_pkg::REG_CFG: q_nxt.cfg = wv[1:0];
        dis_pkg::REG_STAT: q_nxt.br = dis_pkg::RESP_OKAY;
        default: q_nxt.br = dis_pkg::RESP_SLVERR;
      endcase
    end
    if (q_r.bv && bready) begin
      q_nxt.bv = 1'h0;
    end
    if (arvalid && arready) begin
      q_nxt.rv = 1'h1;
      q_nxt.rd = reg_rd(araddr);
      q_nxt.rr = (araddr == dis_pkg::REG_CMD || araddr == dis_pkg::REG_STAT ||
                  araddr == dis_pkg::REG_CFG) ? dis_pkg::RESP_OKAY : dis_pkg::RESP_SLVERR;
    end
    if (q_r.rv && rready) begin
      q_nxt.rv = 1'h0;
    end
    q_nxt.sda_m = link.sda;
    q_nxt.sda_s = q_r.sda_m;
    if (q_r.st != H_IDLE) begin
      q_nxt.qtr = tick ? '0 : q_r.qtr + 1'h1;
    end
    if (tick) begin
      q_nxt.ph = q_r.ph + 1'h1;
    end
    case (q_r.st)
      H_IDLE: begin
        q_nxt.qtr = '0;
        q_nxt.ph = 2'h0;
        if (q_r.busy && q_r.sess) begin
          q_nxt.st = H_BYTE;
          q_nxt.byt = 2'h1;
          q_nxt.sh = byte_val(2'h1);
          q_nxt.bitn = 4'h0;
        end else if (q_r.busy) begin
          q_nxt.st = H_START;
        end
      end
      H_START: begin
        if (tick && q_r.ph == 2'h0) begin
          q_nxt.sda_low = 1'h1;
        end else if (tick && q_r.ph == 2'h1) begin
          q_nxt.scl_low = 1'h1;
          q_nxt.st = H_BYTE;
          q_nxt.ph = 2'h0;
          q_nxt.byt = 2'h0;
          q_nxt.sh = byte_val(2'h0);
          q_nxt.bitn = 4'h0;
        end
      end
      H_BYTE: begin
        if (tick) begin
          case (q_r.ph)
            2'h0: q_nxt.sda_low = (q_r.bitn == dis_pkg::BIT_ACK) ? 1'h0 : !q_r.sh[7];
            2'h1: q_nxt.scl_low = 1'h0;
            2'h2: begin
              if (q_r.bitn == dis_pkg::BIT_ACK && q_r.sda_s) begin
                q_nxt.nack = 1'h1;
              end
            end
            default: begin
              q_nxt.scl_low = 1'h1;
              if (q_r.bitn != dis_pkg::BIT_ACK) begin
                q_nxt.sh = {q_r.sh[6:0], 1'h0};
                q_nxt.bitn = q_r.bitn + 4'h1;
                // free data for acknowledge
                // let go as the eighth bit ends, so slave and master never pull together
                if (q_r.bitn == dis_pkg::BIT_ACK - 4'h1) begin
                  q_nxt.sda_low = 1'h0;
                end
              end else if (q_r.nack) begin
                q_nxt.st = H_STOP;
              end else if (q_r.byt == 2'h3) begin
                if (q_r.cmd[dis_pkg::CMD_KEEP_BIT]) begin
                  q_nxt.st = H_IDLE;
                  q_nxt.busy = 1'h0;
                  q_nxt.sess = 1'h1;
                end else begin
                  q_nxt.st = H_STOP;
                end
              end else begin
                q_nxt.byt = q_r.byt + 2'h1;
                q_nxt.sh = byte_val(q_r.byt + 2'h1);
                q_nxt.bitn = 4'h0;
              end
            end
          endcase
        end
      end
      H_STOP: begin
        if (tick) begin
          case (q_r.ph)
            2'h0: q_nxt.sda_low = 1'h1;
            2'h1: q_nxt.scl_low = 1'h0;
            2'h2: q_nxt.sda_low = 1'h0;
            default: begin
              q_nxt.st = H_IDLE;
              q_nxt.busy = 1'h0;
              q_nxt.sess = 1'h0;
            end
          endcase
        end
      end
      default: q_nxt.st = H_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule

//--- rtl/dis_pkg.sv
// constants shared by both ends of the two-wire dac write port
// assumes a 200 MHz aclk on both ends
package dis_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 5;
  localparam int SCL_MAX_KHZ = 400;
  localparam int SCL_NS = 1000000 / SCL_MAX_KHZ;
  // quarter of the shortest legal bit period, rounded up
  localparam int QTR_CYC = (SCL_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
  localparam int QTR_W = 8;
  localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYC - 1);

  // ****************************************
  // frame layout
  // ****************************************
  localparam logic [4:0] ADDR_FIXED = 5'h15;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam int CH_W = 6;
  localparam int RS_W = 2;
  localparam int DATA_W = 14;
  localparam int UPD_W = RS_W + CH_W + DATA_W;
  localparam int UPD_CH_LSB = DATA_W;
  localparam int UPD_RS_LSB = DATA_W + CH_W;
  localparam int FIFO_DEPTH = 16;

  // ****************************************
  // controller registers
  // ****************************************
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_CFG = 4'h8;
  localparam int CMD_W = 23;
  localparam int CMD_RS_LSB = 6;
  localparam int CMD_DATA_LSB = 8;
  localparam int CMD_KEEP_BIT = 22;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- rtl/dis_link_if.sv
// open-drain two-wire link between controller and dac port
// assumes pull-ups: a line is low only while some end enables its driver
`timescale 1ns/1ps
interface dis_link_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !(m_sda_oe && !m_sda_o) && !(s_sda_oe && !s_sda_o);

  modport master(output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe,
                 input scl, input sda);
  modport slave(output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface

//--- rtl/dis_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes depth is a power of two
`timescale 1ns/1ps
module dis_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input logic aclk,
  input logic aresetn,
  input logic in_valid,
  output logic in_ready,
  input logic [W-1:0] in_data,
  output logic out_valid,
  input logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } dis_fifo_s;

  dis_fifo_s q_r;
  dis_fifo_s q_nxt;
  logic push;
  logic pop;

  assign in_ready = (q_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (q_r.cnt != '0);
  assign out_data = q_r.mem[q_r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    q_nxt = q_r;
    if (push) begin
      q_nxt.mem[q_r.wp] = in_data;
      q_nxt.wp = q_r.wp + 1'h1;
    end
    if (pop) begin
      q_nxt.rp = q_r.rp + 1'h1;
    end
    if (push && !pop) begin
      q_nxt.cnt = q_r.cnt + 1'h1;
    end else if (pop && !push) begin
      q_nxt.cnt = q_r.cnt - 1'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule

//--- rtl/dis_dev.sv
// receive-only two-wire slave port of a multichannel dac
// assumes an external master clocks the link; pins are asynchronous to aclk
`timescale 1ns/1ps
module dis_dev (
  input logic aclk,
  input logic aresetn,
  input logic interface_type_select,
  input logic protocol_select,
  input logic addr_strap_hi,
  input logic addr_strap_lo,
  dis_link_if.slave link,
  output logic port_active,
  output logic upd_valid,
  input logic upd_ready,
  output logic [dis_pkg::CH_W-1:0] upd_channel,
  output logic [dis_pkg::RS_W-1:0] upd_reg_select,
  output logic [dis_pkg::DATA_W-1:0] upd_data
);
  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {
    D_IDLE,
    D_ADDR,
    D_PTR,
    D_MSB,
    D_LSB
  } dis_dev_e;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic [3:0] pin_m;
    logic [3:0] pin_s;
    dis_dev_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic ack;
    logic [dis_pkg::CH_W-1:0] ch;
    logic [dis_pkg::RS_W-1:0] rs;
    logic [5:0] dhi;
    logic push;
  } dis_dev_s;

  dis_dev_s q_r;
  dis_dev_s q_nxt;

  logic scl_hi;
  logic start_cond;
  logic stop_cond;
  logic scl_rise;
  logic scl_fall;
  logic active;
  logic fifo_in_ready;
  logic [dis_pkg::UPD_W-1:0] fifo_in_data;
  logic [dis_pkg::UPD_W-1:0] fifo_out_data;

  // ****************************************
  // line events
  // ****************************************
  // edges are taken on the second sync stage against its own history
  assign scl_hi = q_r.scl_s && q_r.scl_p;
  assign start_cond = scl_hi && q_r.sda_p && !q_r.sda_s;
  assign stop_cond = scl_hi && !q_r.sda_p && q_r.sda_s;
  assign scl_rise = q_r.scl_s && !q_r.scl_p;
  assign scl_fall = !q_r.scl_s && q_r.scl_p;
  assign active = q_r.pin_s[3] && q_r.pin_s[2];
  assign port_active = active;

  // ****************************************
  // byte engine
  // ****************************************
  always_comb begin
    q_nxt = q_r;
    q_nxt.scl_m = link.scl;
    q_nxt.scl_s = q_r.scl_m;
    q_nxt.scl_p = q_r.scl_s;
    q_nxt.sda_m = link.sda;
    q_nxt.sda_s = q_r.sda_m;
    q_nxt.sda_p = q_r.sda_s;
    q_nxt.pin_m = {interface_type_select, protocol_select, addr_strap_hi, addr_strap_lo};
    q_nxt.pin_s = q_r.pin_m;
    q_nxt.push = 1'h0;
    if (!active) begin
      q_nxt.st = D_IDLE;
      q_nxt.ack = 1'h0;
    end else if (start_cond) begin
      q_nxt.st = D_ADDR;
      q_nxt.cnt = 4'h0;
      q_nxt.ack = 1'h0;
    end else if (stop_cond) begin
      q_nxt.st = D_IDLE;
      q_nxt.ack = 1'h0;
    end else if (q_r.st != D_IDLE) begin
      if (scl_rise && q_r.cnt != dis_pkg::BIT_ACK) begin
        q_nxt.sh = {q_r.sh[6:0], q_r.sda_s};
        q_nxt.cnt = q_r.cnt + 4'h1;
      end
      if (scl_fall && q_r.cnt == dis_pkg::BIT_ACK) begin
        if (q_r.ack) begin
          q_nxt.ack = 1'h0;
          q_nxt.cnt = 4'h0;
          case (q_r.st)
            D_ADDR: begin
              q_nxt.st = D_PTR;
            end
            D_PTR: begin
              q_nxt.st = D_MSB;
            end
            D_MSB: begin
              q_nxt.st = D_LSB;
            end
            D_LSB: begin
              q_nxt.st = D_PTR;
            end
            default: begin
              q_nxt.st = D_IDLE;
            end
          endcase
        end else begin
          case (q_r.st)
            D_ADDR: begin
              if (q_r.sh == {dis_pkg::ADDR_FIXED, q_r.pin_s[1:0], 1'h0}) begin
                q_nxt.ack = 1'h1;
              end else begin
                q_nxt.st = D_IDLE;
              end
            end
            D_PTR: begin
              q_nxt.ch = q_r.sh[dis_pkg::CH_W-1:0];
              q_nxt.ack = 1'h1;
            end
            D_MSB: begin
              q_nxt.rs = q_r.sh[7:6];
              q_nxt.dhi = q_r.sh[5:0];
              q_nxt.ack = 1'h1;
            end
            D_LSB: begin
              // one channel per update
              // a full queue is refused by withholding the acknowledge
              if (fifo_in_ready) begin
                q_nxt.push = 1'h1;
                q_nxt.ack = 1'h1;
              end else begin
                q_nxt.st = D_IDLE;
              end
            end
            default: begin
              q_nxt.st = D_IDLE;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ****************************************
  // line drivers
  // ****************************************
  // acknowledge pulls data low
  assign link.s_sda_o = 1'h0;
  assign link.s_sda_oe = q_r.ack;
  // 125 samples per quarter bit at 400 kHz

  // ****************************************
  // update queue
  // ****************************************
  // select rides with the word
  assign fifo_in_data = {q_r.rs, q_r.ch, q_r.dhi, q_r.sh};

  dis_fifo #(
    .W(dis_pkg::UPD_W),
    .DEPTH(dis_pkg::FIFO_DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(q_r.push),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(upd_valid),
    .out_ready(upd_ready),
    .out_data(fifo_out_data)
  );

  assign upd_data = fifo_out_data[dis_pkg::DATA_W-1:0];
  assign upd_channel = fifo_out_data[dis_pkg::UPD_CH_LSB +: dis_pkg::CH_W];
  assign upd_reg_select = fifo_out_data[dis_pkg::UPD_RS_LSB +: dis_pkg::RS_W];
endmodule

//--- test/dis_link_monitor.sv
// concurrent checks on the open-drain link between controller and dac port
// assumes all link signals come from aclk registers, so no sync is needed
`timescale 1ns/1ps
module dis_link_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // ****************************************
  // frame tracking
  // ****************************************
  logic scl_q, sda_q, in_frame, first_byte, start, stop;
  logic [3:0] bit_cnt;
  logic [7:0] sh;
  logic [9:0] per_cnt, ack_cnt;

  assign start = scl && scl_q && sda_q && !sda;
  assign stop = scl && scl_q && !sda_q && sda;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      in_frame <= 1'b0;
      first_byte <= 1'b0;
      bit_cnt <= 4'h0;
      sh <= 8'h00;
      per_cnt <= 10'h3FF;
      ack_cnt <= 10'h000;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        in_frame <= 1'b1;
        first_byte <= 1'b1;
        bit_cnt <= 4'h0;
      end else if (stop) begin
        in_frame <= 1'b0;
      end else if (scl && !scl_q) begin
        bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
        if (bit_cnt == 4'h8)
          first_byte <= 1'b0;
        else
          sh <= {sh[6:0], sda};
      end
      // saturate so a long idle never wraps into a short period
      per_cnt <= (!scl && scl_q) ? 10'h000 : (&per_cnt) ? per_cnt : per_cnt + 10'h001;
      ack_cnt <= s_sda_oe ? ack_cnt + 10'h001 : 10'h000;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_ack_slot;
    $rose(s_sda_oe) |-> in_frame && bit_cnt == 4'h8 && !scl;
  endproperty
  a_ack_slot: assert property (p_ack_slot) else $error("ack outside ninth bit");
  property p_ack_len;
    $fell(s_sda_oe) |-> ack_cnt >= 10'h1EF && ack_cnt <= 10'h1F9;
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack length wrong");
  property p_addr;
    $rose(s_sda_oe) && first_byte |-> sh[7:3] == dis_pkg::ADDR_FIXED && !sh[0];
  endproperty
  a_addr: assert property (p_addr) else $error("ack on foreign address");
  property p_idle_after_stop;
    stop |=> !s_sda_oe [*8];
  endproperty
  a_idle_after_stop: assert property (p_idle_after_stop) else $error("drive after stop");
  property p_slave_steady;
    scl && $past(scl) |-> $stable(s_sda_oe);
  endproperty
  a_slave_steady: assert property (p_slave_steady) else $error("slave moved sda high");
  property p_rate;
    $fell(scl) |-> per_cnt >= 10'h1F3;
  endproperty
  a_rate: assert property (p_rate) else $error("clock period too short");
  property p_master_clock;
    $fell(scl) |-> m_scl_oe;
  endproperty
  a_master_clock: assert property (p_master_clock) else $error("clock not from master");
  property p_no_clash;
    s_sda_oe |-> !m_sda_oe;
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive sda");

  cover property (start);
  cover property ($rose(s_sda_oe) && first_byte);
  cover property ($rose(s_sda_oe) && !first_byte);
  cover property (stop);
endmodule

//--- test/dac_i2c_slave_write_port_tb_top.sv
// bench: controller and dac port joined over one link, driven over axi4-lite
// assumes a 200 MHz aclk; straps at 2'b10 outside the refusal scenario, so the target is 2
`timescale 1ns/1ps
module dac_i2c_slave_write_port_tb_top;
  logic aclk, aresetn, interface_type_select, protocol_select;
  logic addr_strap_hi, addr_strap_lo, port_active, upd_valid, upd_ready;
  logic [dis_pkg::CH_W-1:0] upd_channel;
  logic [dis_pkg::RS_W-1:0] upd_reg_select;
  logic [dis_pkg::DATA_W-1:0] upd_data;
  logic [3:0] awaddr, araddr, wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int fails, num_checks;

  dis_link_if u_dis_link_if ();
  dis_host u_dis_host (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .link(u_dis_link_if));
  dis_dev u_dis_dev (.aclk, .aresetn, .interface_type_select, .protocol_select, .addr_strap_hi,
    .addr_strap_lo, .link(u_dis_link_if), .port_active, .upd_valid, .upd_ready, .upd_channel,
    .upd_reg_select, .upd_data);
  dis_link_monitor u_dis_link_monitor (.aclk, .aresetn, .m_scl_oe(u_dis_link_if.m_scl_oe),
    .m_sda_oe(u_dis_link_if.m_sda_oe), .s_sda_oe(u_dis_link_if.s_sda_oe),
    .scl(u_dis_link_if.scl), .sda(u_dis_link_if.sda));

  always #2.5 aclk = ~aclk;

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // one channel update; polls until the controller is no longer busy
  task automatic send(input logic [5:0] ch, input logic [1:0] rs, input logic [13:0] d,
      input logic keep, output logic [31:0] st);
    logic [1:0] r;
    axw(dis_pkg::REG_CMD, {9'h000, keep, d, rs, ch}, r);
    chk(r, dis_pkg::RESP_OKAY);
    st = 32'h1;
    while (st[0] !== 1'b0) axr(dis_pkg::REG_STAT, st, r);
  endtask

  task automatic pop(input logic [5:0] ch, input logic [1:0] rs, input logic [13:0] d);
    @(posedge aclk);
    chk(upd_valid, 1'b1);
    chk(upd_channel, ch);
    chk(upd_reg_select, rs);
    chk(upd_data, d);
    upd_ready <= 1'b1;
    @(posedge aclk);
    upd_ready <= 1'b0;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic s_regs;
    logic [31:0] d;
    logic [1:0] r;
    axr(dis_pkg::REG_CFG, d, r);
    chk(d, 32'h0);
    axr(dis_pkg::REG_STAT, d, r);
    chk(d, 32'h0);
    axw(dis_pkg::REG_CFG, 32'h2, r);
    chk(r, dis_pkg::RESP_OKAY);
    axr(dis_pkg::REG_CFG, d, r);
    chk(d, 32'h2);
    axr(4'hC, d, r);
    chk(r, dis_pkg::RESP_SLVERR);
    chk(d, 32'h0);
  endtask

  task automatic s_single;
    logic [31:0] st;
    send(6'h2A, 2'h0, 14'h2ABC, 1'b0, st);
    chk(st[2:1], 2'h0);
    pop(6'h2A, 2'h0, 14'h2ABC);
    @(posedge aclk);
    chk(upd_valid, 1'b0);
  endtask

  // consumer stalls while three updates queue up in one session
  task automatic s_multi;
    logic [31:0] st;
    send(6'h05, 2'h1, 14'h1234, 1'b1, st);
    chk(st[2:1], 2'h2);
    send(6'h27, 2'h2, 14'h0F0F, 1'b1, st);
    chk(st[2:1], 2'h2);
    send(6'h3F, 2'h3, 14'h3FFF, 1'b0, st);
    chk(st[2:1], 2'h0);
    pop(6'h05, 2'h1, 14'h1234);
    pop(6'h27, 2'h2, 14'h0F0F);
    pop(6'h3F, 2'h3, 14'h3FFF);
  endtask

  task automatic s_refuse;
    logic [31:0] st;
    logic [1:0] r;
    axw(dis_pkg::REG_CFG, 32'h1, r);
    send(6'h01, 2'h0, 14'h0001, 1'b0, st);
    chk(st[1], 1'b1);
    chk(upd_valid, 1'b0);
    axw(dis_pkg::REG_CFG, 32'h2, r);
    // moved straps must take the port away from target 2
    addr_strap_hi <= 1'h0;
    addr_strap_lo <= 1'h1;
    repeat (6) @(posedge aclk);
    send(6'h03, 2'h0, 14'h0003, 1'b0, st);
    chk(st[1], 1'h1);
    chk(upd_valid, 1'h0);
    addr_strap_hi <= 1'h1;
    addr_strap_lo <= 1'h0;
    protocol_select <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(port_active, 1'b0);
    send(6'h02, 2'h0, 14'h0002, 1'b0, st);
    chk(st[1], 1'b1);
    chk(upd_valid, 1'b0);
    protocol_select <= 1'b1;
    interface_type_select <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(port_active, 1'b0);
    interface_type_select <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(port_active, 1'b1);
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    interface_type_select = 1'b1;
    protocol_select = 1'b1;
    addr_strap_hi = 1'b1;
    addr_strap_lo = 1'b0;
    upd_ready = 1'b0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    fails = 0;
    num_checks = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(port_active, 1'b1);
    s_regs;
    s_single;
    s_multi;
    s_refuse;
    results;
  end

  // whole run is near 80k cycles; this cuts a hang before the 100k budget
  initial begin
    #(95000 * 5);
    fails++;
    results;
  end
endmodule
